// [urf_regfile.sv]
`timescale 1ns/1ps
`include "urf_map.svh"
// Summary of operation
// - accumulator is sixteen 4-bit digits
// - fifteen data digits, top digit holds flags
// - accumulator accessed whole or by digit
// - four index registers, 8 or 16 bits
// - index counters wrap modulo their width
// - counter at limit sets limit flag
// - divide leaves remainder with flag digit
// - scale 0-15 shifts product right digits
// - divide quotient has scale fraction digits
// - absolute 16-bit key table base address
// - enabled key at halt fetches table entry
// - key enable is two 8-bit groups
// - key enable clears after keyboard instruction
// - zero send base selects transmit buffer
// - send addressing adds pointer in extended variant or with data handling
// - pointers are 16 or 8 bit counters
// - zero receive base selects receive buffer
// - receive base needs data-handling segment
// - receive base offset by receive pointer
// - word addresses relative to user memory base
// - program start clears listed registers
module urf_regfile (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // variant and firmware straps
   input wire logic extended_variant_i,
   input wire logic data_handling_i,
   input wire logic dh_segment1_i,
   input wire logic [15:0] user_mem_base_i,
   // instruction register port
   input wire urf_pkg::urf_req_t req_i,
   // arithmetic unit results
   input wire logic rem_load_i,
   input wire logic [59:0] rem_data_i,
   input wire logic [3:0] rem_flags_i,
   // index counter operations
   input wire urf_pkg::urf_idx_op_t idx_op_i,
   input wire logic [1:0] idx_num_i,
   input wire logic [15:0] idx_lim_i,
   input wire logic lim_flag_clr_i,
   // keyboard events
   input wire logic kbd_halt_key_i,
   input wire logic [3:0] kbd_key_num_i,
   input wire logic kbd_key_grp_i,
   input wire logic kbd_instr_done_i,
   // character pointer advance
   input wire logic send_ptr_inc_i,
   input wire logic recv_ptr_inc_i,
   // register read data
   output logic [63:0] rdata_o,
   // arithmetic operands
   output logic [59:0] acc_data_o,
   output logic [3:0] acc_flags_o,
   output logic [3:0] scale_o,
   // index and limit flags
   output logic [3:0] lim_flag_o,
   // implied addressing
   output logic [15:0] dst_addr_o,
   output logic dst_to_buf_o,
   output logic [15:0] src_addr_o,
   output logic src_to_buf_o,
   // key table fetch
   output logic key_fetch_o,
   output logic [15:0] key_entry_addr_o
);
   urf_pkg::urf_state_t s_r, s_nxt;
   logic [15:0] wmask;
   logic [15:0] idx_cur, idx_new, send_ptr_m, recv_ptr_m;
   logic [15:0] send_ptr_w, recv_ptr_w;
   logic idx_inc, idx_dec;
   logic [3:0] key_bit;
   logic [63:0] rd;

   // width mask for the selected variant
   assign wmask = extended_variant_i ? 16'hFFFF : 16'h00FF;

   // shared index step on the register picked by idx_num_i
   assign idx_cur = s_r.idx[idx_num_i];
   assign idx_inc = (idx_op_i == urf_pkg::URF_IDX_INC);
   assign idx_dec = (idx_op_i == urf_pkg::URF_IDX_DEC);
   urf_wrap_step #(.W(16)) u_urf_wrap_step_idx (
      .cur_i(idx_cur),
      .mask_i(wmask),
      .inc_i(idx_inc),
      .dec_i(idx_dec),
      .nxt_o(idx_new)
   );

   // pointer values after a same-cycle port write, so an advance lands on top
   assign send_ptr_w = (req_i.wr && req_i.sel == `URF_SEL_SEND_PTR) ? (req_i.wdata[15:0] & wmask) : s_r.send_ptr;
   assign recv_ptr_w = (req_i.wr && req_i.sel == `URF_SEL_RECV_PTR) ? (req_i.wdata[15:0] & wmask) : s_r.recv_ptr;

   // send character pointer step
   urf_wrap_step #(.W(16)) u_urf_wrap_step_send (
      .cur_i(send_ptr_w),
      .mask_i(wmask),
      .inc_i(send_ptr_inc_i),
      .dec_i(1'b0),
      .nxt_o(send_ptr_m)
   );

   // receive character pointer step
   urf_wrap_step #(.W(16)) u_urf_wrap_step_recv (
      .cur_i(recv_ptr_w),
      .mask_i(wmask),
      .inc_i(recv_ptr_inc_i),
      .dec_i(1'b0),
      .nxt_o(recv_ptr_m)
   );

   // next state for all registers
   always_comb begin
      s_nxt = s_r;
      // instruction port writes, one per cycle
      if (req_i.wr) begin
         case (req_i.sel)
            `URF_SEL_ACC: s_nxt.acc = req_i.wdata;
            `URF_SEL_ACC_DIGIT: s_nxt.acc[req_i.digit*`URF_DIGIT_W +: `URF_DIGIT_W] = req_i.wdata[3:0];
            `URF_SEL_IDX0: s_nxt.idx[0] = req_i.wdata[15:0] & wmask;
            `URF_SEL_IDX1: s_nxt.idx[1] = req_i.wdata[15:0] & wmask;
            `URF_SEL_IDX2: s_nxt.idx[2] = req_i.wdata[15:0] & wmask;
            `URF_SEL_IDX3: s_nxt.idx[3] = req_i.wdata[15:0] & wmask;
            `URF_SEL_REM: s_nxt.rem = req_i.wdata;
            `URF_SEL_SCALE: s_nxt.scale = req_i.wdata[3:0];
            `URF_SEL_KEY_TABLE: s_nxt.key_table = req_i.wdata[15:0];
            `URF_SEL_KEY_EN: s_nxt.key_en = req_i.wdata[15:0];
            `URF_SEL_SEND_BASE: s_nxt.send_base = req_i.wdata[15:0];
            `URF_SEL_SEND_PTR: s_nxt.send_ptr = req_i.wdata[15:0] & wmask;
            `URF_SEL_RECV_BASE: s_nxt.recv_base = req_i.wdata[15:0];
            `URF_SEL_RECV_PTR: s_nxt.recv_ptr = req_i.wdata[15:0] & wmask;
            `URF_SEL_IDX_LIMIT: s_nxt.idx_lim[req_i.digit[1:0]] = req_i.wdata[15:0] & wmask;
            default: ;
         endcase
      end
      // divide remainder with its flag digit on top
      if (rem_load_i) begin
         s_nxt.rem = {rem_flags_i, rem_data_i};
      end
      // limit flag clear; a same-cycle set below wins
      if (lim_flag_clr_i) begin
         s_nxt.lim_flag[idx_num_i] = 1'b0;
      end
      if (idx_op_i != urf_pkg::URF_IDX_NONE) begin
         s_nxt.idx[idx_num_i] = idx_new;
         s_nxt.idx_lim[idx_num_i] = idx_lim_i & wmask;
         if (idx_new == (idx_lim_i & wmask)) begin
            s_nxt.lim_flag[idx_num_i] = 1'b1; // set wins over clear
         end
      end
      // pointer advance, wrapping in the variant width
      if (send_ptr_inc_i) begin
         s_nxt.send_ptr = send_ptr_m;
      end
      if (recv_ptr_inc_i) begin
         s_nxt.recv_ptr = recv_ptr_m;
      end
      // key press at halt fetches from table
      key_bit = {kbd_key_grp_i, kbd_key_num_i[2:0]}; // group picks the upper or lower byte
      s_nxt.key_fetch = kbd_halt_key_i && s_r.key_en[key_bit[3:0]];
      s_nxt.key_entry_addr = s_r.key_table + {11'h000, key_bit[3:0], 1'b0};
      if (kbd_instr_done_i) begin
         s_nxt.key_en = `URF_RST_16;
      end
      // implied destination addressing
      s_nxt.dst_to_buf = (s_r.send_base == `URF_RST_16);
      if (extended_variant_i || data_handling_i) begin
         s_nxt.dst_addr = s_r.send_base + s_r.send_ptr;
      end else begin
         s_nxt.dst_addr = s_r.send_base;
      end
      if (!s_nxt.dst_to_buf) begin
         s_nxt.dst_addr = s_nxt.dst_addr + user_mem_base_i;
      end
      // implied source addressing
      if (dh_segment1_i) begin
         s_nxt.src_to_buf = (s_r.recv_base == `URF_RST_16);
         s_nxt.src_addr = s_r.recv_base + s_r.recv_ptr;
         if (!s_nxt.src_to_buf) begin
            s_nxt.src_addr = s_nxt.src_addr + user_mem_base_i;
         end
      end else begin
         s_nxt.src_to_buf = 1'b0;
         s_nxt.src_addr = `URF_RST_16;
      end
      // registered read data
      case (req_i.sel)
         `URF_SEL_ACC: rd = s_r.acc;
         `URF_SEL_ACC_DIGIT: rd = {60'h0, s_r.acc[req_i.digit*`URF_DIGIT_W +: `URF_DIGIT_W]};
         `URF_SEL_IDX0: rd = {48'h0, s_r.idx[0]};
         `URF_SEL_IDX1: rd = {48'h0, s_r.idx[1]};
         `URF_SEL_IDX2: rd = {48'h0, s_r.idx[2]};
         `URF_SEL_IDX3: rd = {48'h0, s_r.idx[3]};
         `URF_SEL_REM: rd = s_r.rem;
         `URF_SEL_SCALE: rd = {60'h0, s_r.scale};
         `URF_SEL_KEY_TABLE: rd = {48'h0, s_r.key_table};
         `URF_SEL_KEY_EN: rd = {48'h0, s_r.key_en};
         `URF_SEL_SEND_BASE: rd = {48'h0, s_r.send_base};
         `URF_SEL_SEND_PTR: rd = {48'h0, s_r.send_ptr};
         `URF_SEL_RECV_BASE: rd = {48'h0, s_r.recv_base};
         `URF_SEL_RECV_PTR: rd = {48'h0, s_r.recv_ptr};
         `URF_SEL_IDX_LIMIT: rd = {48'h0, s_r.idx_lim[req_i.digit[1:0]]};
         default: rd = 64'h0;
      endcase
      s_nxt.rdata = rd;
   end

   // state register; accumulator keeps its value through program start
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin // accumulator left out of reset
         s_r.idx <= '0;
         s_r.idx_lim <= '0;
         s_r.lim_flag <= '0;
         s_r.rem <= `URF_RST_64;
         s_r.scale <= `URF_RST_4;
         s_r.key_table <= `URF_RST_16;
         s_r.key_en <= `URF_RST_16;
         s_r.send_base <= `URF_RST_16;
         s_r.send_ptr <= `URF_RST_16;
         s_r.recv_base <= `URF_RST_16;
         s_r.recv_ptr <= `URF_RST_16;
         s_r.rdata <= `URF_RST_64;
         s_r.dst_addr <= `URF_RST_16;
         s_r.src_addr <= `URF_RST_16;
         s_r.dst_to_buf <= 1'b1;
         s_r.src_to_buf <= 1'b0;
         s_r.key_entry_addr <= `URF_RST_16;
         s_r.key_fetch <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flip-flops
   assign rdata_o = s_r.rdata;
   assign acc_data_o = s_r.acc[59:0];
   assign acc_flags_o = s_r.acc[63:60];
   assign scale_o = s_r.scale;
   assign lim_flag_o = s_r.lim_flag;
   assign dst_addr_o = s_r.dst_addr;
   assign dst_to_buf_o = s_r.dst_to_buf;
   assign src_addr_o = s_r.src_addr;
   assign src_to_buf_o = s_r.src_to_buf;
   assign key_fetch_o = s_r.key_fetch;
   assign key_entry_addr_o = s_r.key_entry_addr;
endmodule : urf_regfile

// one masked step of a wrapping counter; the mask sets the live width
module urf_wrap_step #(
   parameter int W = 16
) (
   // current value and live-width mask
   input wire logic [W-1:0] cur_i,
   input wire logic [W-1:0] mask_i,
   // step direction, increment taking priority
   input wire logic inc_i,
   input wire logic dec_i,
   // stepped value, or the current one when idle
   output logic [W-1:0] nxt_o
);
   // masking after the add or subtract wraps all-ones to zero and back
   always_comb begin
      if (inc_i) begin
         nxt_o = (cur_i + W'(1)) & mask_i;
      end else if (dec_i) begin
         nxt_o = (cur_i - W'(1)) & mask_i;
      end else begin
         nxt_o = cur_i;
      end
   end
endmodule : urf_wrap_step

// [urf_map.svh]
`ifndef URF_MAP_SVH
`define URF_MAP_SVH
// register select indices on the instruction port
`define URF_SEL_ACC 4'h0
`define URF_SEL_ACC_DIGIT 4'h1
`define URF_SEL_IDX0 4'h2
`define URF_SEL_IDX1 4'h3
`define URF_SEL_IDX2 4'h4
`define URF_SEL_IDX3 4'h5
`define URF_SEL_REM 4'h6
`define URF_SEL_SCALE 4'h7
`define URF_SEL_KEY_TABLE 4'h8
`define URF_SEL_KEY_EN 4'h9
`define URF_SEL_SEND_BASE 4'hA
`define URF_SEL_SEND_PTR 4'hB
`define URF_SEL_RECV_BASE 4'hC
`define URF_SEL_RECV_PTR 4'hD
`define URF_SEL_IDX_LIMIT 4'hE
// field positions and widths
`define URF_DIGIT_W 4
`define URF_FLAG_DIGIT 4'hF
`define URF_DATA_DIGITS 15
`define URF_COMPACT_W 8
`define URF_KEY_GRP_W 8
// reset values
`define URF_RST_16 16'h0000
`define URF_RST_64 64'h0000_0000_0000_0000
`define URF_RST_4 4'h0
`endif

// [urf_pkg.sv]
package urf_pkg;
   // instruction port request
   typedef struct packed {
      logic wr;
      logic [3:0] sel;
      logic [3:0] digit;
      logic [63:0] wdata;
   } urf_req_t;
   // index counter operation
   typedef enum logic [1:0] {URF_IDX_NONE, URF_IDX_INC, URF_IDX_DEC} urf_idx_op_t;
   // complete state of the register file
   typedef struct packed {
      logic [63:0] acc;
      logic [63:0] rem;
      logic [3:0][15:0] idx;
      logic [3:0][15:0] idx_lim;
      logic [3:0] lim_flag;
      logic [3:0] scale;
      logic [15:0] key_table;
      logic [15:0] key_en;
      logic [15:0] send_base;
      logic [15:0] send_ptr;
      logic [15:0] recv_base;
      logic [15:0] recv_ptr;
      logic [63:0] rdata;
      logic [15:0] dst_addr;
      logic [15:0] src_addr;
      logic dst_to_buf;
      logic src_to_buf;
      logic [15:0] key_entry_addr;
      logic key_fetch;
   } urf_state_t;
endpackage : urf_pkg

// [urf_regfile_monitor.sv]
`timescale 1ns/1ps
`include "urf_map.svh"
module urf_regfile_monitor (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // watched inputs
   input wire logic dh_segment1_i,
   input wire urf_pkg::urf_req_t req_i,
   input wire logic rem_load_i,
   input wire logic [59:0] rem_data_i,
   input wire logic [3:0] rem_flags_i,
   input wire logic kbd_halt_key_i,
   input wire logic kbd_instr_done_i,
   // watched outputs
   input wire logic [63:0] rdata_o,
   input wire logic [15:0] src_addr_o,
   input wire logic src_to_buf_o,
   input wire logic key_fetch_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   // remainder load, then a remainder read
   sequence s_rem_read;
      rem_load_i ##1 req_i.sel == `URF_SEL_REM;
   endsequence
   // keyboard instruction end, then a key enable read
   sequence s_en_read;
      kbd_instr_done_i && !req_i.wr ##1 req_i.sel == `URF_SEL_KEY_EN;
   endsequence
   // register read, pulse and receive addressing checks
   a_rem_load_value: assert property (s_rem_read |=> rdata_o == {$past(rem_flags_i, 2), $past(rem_data_i, 2)})
      else $error("remainder read differs from loaded value");
   a_key_en_clear: assert property (s_en_read |=> rdata_o == 64'h0)
      else $error("key enable not cleared after keyboard instruction");
   a_unknown_sel_zero: assert property (req_i.sel == 4'hF |=> rdata_o == 64'h0)
      else $error("unmapped select returned nonzero data");
   a_scale_four_bits: assert property (req_i.sel == `URF_SEL_SCALE |=> rdata_o[63:4] == 60'h0)
      else $error("scale read wider than four bits");
   a_index_width: assert property (req_i.sel inside {[`URF_SEL_IDX0:`URF_SEL_IDX3]} |=> rdata_o[63:16] == 48'h0)
      else $error("index read wider than sixteen bits");
   a_fetch_single: assert property (key_fetch_o |=> !key_fetch_o)
      else $error("key fetch longer than one cycle");
   a_fetch_cause: assert property (key_fetch_o |-> $past(kbd_halt_key_i))
      else $error("key fetch without keyboard halt key");
   a_src_ignored: assert property (!$past(dh_segment1_i) && !$past(dh_segment1_i, 2) |->
      !src_to_buf_o && src_addr_o == 16'h0)
      else $error("receive base active without data handling segment");
endmodule : urf_regfile_monitor
bind urf_regfile urf_regfile_monitor u_urf_regfile_monitor (.core_clk_i, .arst_n_i, .dh_segment1_i, .req_i,
   .rem_load_i, .rem_data_i, .rem_flags_i, .kbd_halt_key_i, .kbd_instr_done_i, .rdata_o, .src_addr_o,
   .src_to_buf_o, .key_fetch_o);

// [tb_urf_regfile.sv]
`timescale 1ns/1ps
`include "urf_map.svh"
module tb_urf_regfile;
   typedef struct packed {logic [3:0] s; logic [3:0] d; logic [63:0] v; logic [63:0] e;} urf_row_t;
   // design inputs and outputs
   logic core_clk_i, arst_n_i, extended_variant_i, data_handling_i, dh_segment1_i, rem_load_i, lim_flag_clr_i;
   logic kbd_halt_key_i, kbd_key_grp_i, kbd_instr_done_i, send_ptr_inc_i, recv_ptr_inc_i;
   logic key_fetch_o, dst_to_buf_o, src_to_buf_o;
   logic [1:0] idx_num_i;
   logic [3:0] rem_flags_i, kbd_key_num_i, acc_flags_o, scale_o, lim_flag_o;
   logic [15:0] user_mem_base_i, idx_lim_i, dst_addr_o, src_addr_o, key_entry_addr_o, a;
   logic [59:0] rem_data_i, acc_data_o;
   logic [63:0] rdata_o;
   urf_pkg::urf_req_t req_i;
   urf_pkg::urf_idx_op_t idx_op_i;
   urf_row_t rows [14];
   int bad_count, samples_checked, i, n;
   urf_regfile u_urf_regfile (.core_clk_i, .arst_n_i, .extended_variant_i, .data_handling_i, .dh_segment1_i,
      .user_mem_base_i, .req_i, .rem_load_i, .rem_data_i, .rem_flags_i, .idx_op_i, .idx_num_i, .idx_lim_i,
      .lim_flag_clr_i, .kbd_halt_key_i, .kbd_key_num_i, .kbd_key_grp_i, .kbd_instr_done_i, .send_ptr_inc_i,
      .recv_ptr_inc_i, .rdata_o, .acc_data_o, .acc_flags_o, .scale_o, .lim_flag_o, .dst_addr_o, .dst_to_buf_o,
      .src_addr_o, .src_to_buf_o, .key_fetch_o, .key_entry_addr_o);
   // compare and drive helpers
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic put(input logic w, input logic [3:0] s, input logic [3:0] d, input logic [63:0] v);
      @(posedge core_clk_i);
      req_i <= '{w, s, d, v};
   endtask : put
   task automatic wr(input logic [3:0] s, input logic [3:0] d, input logic [63:0] v);
      put(1'b1, s, d, v);
      @(posedge core_clk_i);
      req_i.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] s, input logic [3:0] d, input logic [63:0] e, input string nm);
      put(1'b0, s, d, 64'h0);
      @(posedge core_clk_i);
      #1 chk(nm, e, rdata_o);
   endtask : rd
   task automatic op(input urf_pkg::urf_idx_op_t k, input logic [1:0] m);
      @(posedge core_clk_i);
      idx_op_i <= k;
      idx_num_i <= m;
      @(posedge core_clk_i);
      idx_op_i <= urf_pkg::URF_IDX_NONE;
   endtask : op
   // halt with one key, count fetch pulses in a bounded window
   task automatic key(input logic g);
      @(posedge core_clk_i);
      kbd_key_grp_i <= g;
      kbd_halt_key_i <= 1'b1;
      @(posedge core_clk_i);
      kbd_halt_key_i <= 1'b0;
      n = 0;
      repeat (4) begin
         #1 if (key_fetch_o === 1'b1) begin
            n++;
            a = key_entry_addr_o;
         end
         @(posedge core_clk_i);
      end
   endtask : key
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // free-running clock
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   // main sequence
   initial begin
      {arst_n_i, data_handling_i, rem_load_i, lim_flag_clr_i, kbd_halt_key_i, kbd_key_grp_i} = '0;
      {kbd_instr_done_i, send_ptr_inc_i, recv_ptr_inc_i, idx_num_i, rem_flags_i, kbd_key_num_i, rem_data_i} = '0;
      {extended_variant_i, dh_segment1_i, user_mem_base_i, idx_lim_i} = {2'b11, 16'h1000, 16'h0001};
      req_i = '0;
      idx_op_i = urf_pkg::URF_IDX_NONE;
      rows = '{'{`URF_SEL_ACC, 4'h0, 64'hF123456789ABCDEF, 64'hF123456789ABCDEF},
         '{`URF_SEL_ACC_DIGIT, 4'h3, 64'h0, 64'h0}, '{`URF_SEL_IDX0, 4'h0, 64'hFFFFFFFFFFFFABCD, 64'hABCD},
         '{`URF_SEL_IDX3, 4'h0, 64'h5555, 64'h5555}, '{`URF_SEL_REM, 4'h0, 64'h8000000000000042, 64'h8000000000000042},
         '{`URF_SEL_SCALE, 4'h0, 64'hF, 64'hF}, '{`URF_SEL_KEY_TABLE, 4'h0, 64'h200, 64'h200},
         '{`URF_SEL_KEY_EN, 4'h0, 64'h100, 64'h100}, '{`URF_SEL_SEND_BASE, 4'h0, 64'h40, 64'h40},
         '{`URF_SEL_SEND_PTR, 4'h0, 64'h3, 64'h3}, '{`URF_SEL_RECV_BASE, 4'h0, 64'h80, 64'h80},
         '{`URF_SEL_RECV_PTR, 4'h0, 64'h5, 64'h5}, '{`URF_SEL_IDX_LIMIT, 4'h1, 64'h1, 64'h1}, '{4'hF, 4'h0, 64'h1, 64'h0}};
      repeat (4) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      for (i = 2; i < 13; i++) rd(i[3:0], 4'h0, 64'h0, "reset value");
      chk("send to buffer", 64'h1, {63'h0, dst_to_buf_o});
      chk("receive to buffer", 64'h1, {63'h0, src_to_buf_o});
      // word-aligned bases only
      for (i = 0; i < 14; i++) begin
         wr(rows[i].s, rows[i].d, rows[i].v);
         rd(rows[i].s, rows[i].d, rows[i].e, "row read");
      end
      rd(`URF_SEL_ACC, 4'h0, 64'hF123456789AB0DEF, "digit merge");
      chk("acc flags", 64'hF, {60'h0, acc_flags_o});
      chk("acc data", 64'h0123456789AB0DEF, {4'h0, acc_data_o});
      chk("scale out", 64'hF, {60'h0, scale_o});
      chk("send address", 64'h1043, {48'h0, dst_addr_o});
      chk("receive address", 64'h1085, {48'h0, src_addr_o});
      chk("send to memory", 64'h0, {63'h0, dst_to_buf_o});
      chk("receive from memory", 64'h0, {63'h0, src_to_buf_o});
      // pointer advance, index wrap and limit
      @(posedge core_clk_i) {send_ptr_inc_i, recv_ptr_inc_i} <= 2'b11;
      @(posedge core_clk_i) {send_ptr_inc_i, recv_ptr_inc_i} <= 2'b00;
      rd(`URF_SEL_RECV_PTR, 4'h0, 64'h6, "receive pointer step");
      wr(`URF_SEL_IDX1, 4'h0, 64'hFFFF);
      op(urf_pkg::URF_IDX_INC, 2'd1);
      rd(`URF_SEL_IDX1, 4'h0, 64'h0, "index wrap up");
      op(urf_pkg::URF_IDX_INC, 2'd1);
      repeat (2) @(posedge core_clk_i);
      #1 chk("limit flag", 64'h2, {60'h0, lim_flag_o});
      @(posedge core_clk_i) lim_flag_clr_i <= 1'b1;
      @(posedge core_clk_i) lim_flag_clr_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1 chk("limit flag clear", 64'h0, {60'h0, lim_flag_o});
      op(urf_pkg::URF_IDX_DEC, 2'd1);
      op(urf_pkg::URF_IDX_DEC, 2'd1);
      rd(`URF_SEL_IDX1, 4'h0, 64'hFFFF, "index wrap down");
      // compact variant widths and addressing
      @(posedge core_clk_i) extended_variant_i <= 1'b0;
      wr(`URF_SEL_IDX2, 4'h0, 64'h1200);
      op(urf_pkg::URF_IDX_DEC, 2'd2);
      rd(`URF_SEL_IDX2, 4'h0, 64'hFF, "compact wrap");
      chk("compact direct address", 64'h1040, {48'h0, dst_addr_o});
      @(posedge core_clk_i) data_handling_i <= 1'b1;
      @(posedge core_clk_i) dh_segment1_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1 chk("compact char address", 64'h1044, {48'h0, dst_addr_o});
      chk("receive ignored", 64'h0, {src_to_buf_o, 47'h0, src_addr_o});
      // key table fetch and enable clear
      key(1'b0);
      chk("disabled key", 64'h0, 64'(n));
      key(1'b1);
      chk("enabled key", 64'h1, 64'(n));
      chk("key entry", 64'h210, {48'h0, a});
      @(posedge core_clk_i) kbd_instr_done_i <= 1'b1;
      req_i <= '{1'b0, `URF_SEL_KEY_EN, 4'h0, 64'h0};
      @(posedge core_clk_i) kbd_instr_done_i <= 1'b0;
      @(posedge core_clk_i);
      #1 chk("key enable clear", 64'h0, rdata_o);
      // divide remainder load
      @(posedge core_clk_i) {rem_load_i, rem_flags_i, rem_data_i} <= {1'b1, 4'hA, 60'h123};
      req_i <= '{1'b0, `URF_SEL_REM, 4'h0, 64'h0};
      @(posedge core_clk_i) rem_load_i <= 1'b0;
      @(posedge core_clk_i);
      #1 chk("remainder load", 64'hA000000000000123, rdata_o);
      // reset in mid-run
      @(posedge core_clk_i) arst_n_i <= 1'b0;
      @(posedge core_clk_i) arst_n_i <= 1'b1;
      rd(`URF_SEL_SCALE, 4'h0, 64'h0, "scale after reset");
      report_and_stop();
   end
endmodule : tb_urf_regfile
